// *** bench/adc_host_register_port_tb_top.sv ***
// Self-checking bench for the converter register port
`timescale 1ns/1ps
`default_nettype none
module adc_host_register_port_tb_top import arp_pkg::*;;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic cs_n, oe_n, wr_n, register_select_high, register_select_low;
    logic [DATA_W-1:0] data_in, data_out, core_sample_code, bus_wire, rd;
    logic [DATA_W-1:0] last_bus = 14'h0000;
    logic data_oe, core_range_exceed, range_exceed_flag, test_mode_active;
    logic write_ready, power_down_bit, external_reference;
    logic [GAIN_W-1:0] gain_code;
    logic [TEST_W-1:0] test_input_select;
    int error_cnt = 0;
    int checked = 0;
    always #50 clock = ~clock;
    // Undriven data lines show the inverse of their last value
    assign bus_wire = (data_oe === 1'b1) ? data_out : ~last_bus;
    always @(posedge clock) if (data_oe === 1'b1) last_bus <= data_out;
    arp_top dut_u (.clock, .arst_n, .cs_n, .oe_n, .wr_n, .register_select_high,
        .register_select_low, .data_in, .data_out, .data_oe, .core_sample_code,
        .core_range_exceed, .range_exceed_flag, .gain_code, .power_down_bit,
        .external_reference, .test_input_select, .test_mode_active,
        .write_ready);
    arp_host_model host_u (.clock, .data_bus(bus_wire), .cs_n, .oe_n, .wr_n,
        .register_select_high, .register_select_low, .data_in);
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [DATA_W-1:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic code_case(input logic [13:0] core, input logic [7:0] trim,
            input logic [13:0] ctrl, exp);
        host_u.write_reg(SEL_TRIM, {6'h3f, trim});
        host_u.write_reg(SEL_CTRL, ctrl);
        core_sample_code = core;
        repeat (12) @(negedge clock);
        host_u.read_reg(SEL_RESULT, rd);
        check(rd, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [2:0] t;
        logic [13:0] w;
        core_sample_code = 14'h2000;
        core_range_exceed = 1'b0;
        repeat (10) @(negedge clock);
        arst_n = 1'b1;
        repeat (3) @(negedge clock);
        for (int i = 1; i < 4; i++) begin
            host_u.read_reg(2'(i), rd);
            check(rd, 14'h0000);
        end
        $display("test reset_values finished");
        for (int i = 0; i < 8; i++) begin
            host_u.write_reg(SEL_GAIN, 14'h3ff8 | 14'(i));
            host_u.read_reg(SEL_GAIN, rd);
            check(rd, 14'(i));
            check(14'(gain_code), 14'(i));
        end
        $display("test gain finished");
        for (int i = 0; i < 8; i++) begin
            t = 3'(i);
            w = {t[0], t[1], 1'b0, t, 8'h00};
            host_u.write_reg(SEL_CTRL, w);
            host_u.read_reg(SEL_CTRL, rd);
            check(rd, w);
            check(14'(power_down_bit), 14'(t[0]));
            check(14'(external_reference), 14'(t[1]));
            check(14'(test_input_select), 14'(t));
            check(14'(test_mode_active), 14'(t[1:0] != 2'h0));
        end
        $display("test control finished");
        code_case(14'h0000, 8'h00, 14'h0000, 14'h0000);
        code_case(14'h3fff, 8'h00, 14'h0000, 14'h3fff);
        code_case(14'h2000, 8'h00, 14'h0800, 14'h0000);
        code_case(14'h0000, 8'h00, 14'h0800, 14'h2000);
        code_case(14'h3fff, 8'h00, 14'h0800, 14'h1fff);
        code_case(14'h2000, 8'h7f, 14'h0000, 14'h207f);
        code_case(14'h2000, 8'h80, 14'h0000, 14'h1f80);
        code_case(14'h2000, 8'h80, 14'h0080, 14'h2000);
        code_case(14'h3ffe, 8'h05, 14'h0000, 14'h3fff);
        code_case(14'h2000, 8'h7f, 14'h0800, 14'h007f);
        host_u.read_reg(SEL_TRIM, rd);
        check(rd, 14'h007f);
        // Zero input reads -3 untrimmed; host stores it as the trim
        code_case(14'h1ffd, 8'h00, 14'h0880, 14'h3ffd);
        host_u.write_reg(SEL_TRIM, rd);
        host_u.read_reg(SEL_TRIM, rd);
        check(rd, 14'h00fd);
        $display("test coding finished");
        code_case(14'h0155, 8'h00, 14'h0000, 14'h0155);
        host_u.open_read(SEL_RESULT);
        repeat (5) @(negedge clock);
        core_sample_code = 14'h2aaa;
        core_range_exceed = 1'b1;
        @(negedge clock);
        core_sample_code = 14'h0155;
        core_range_exceed = 1'b0;
        repeat (9) @(posedge clock);
        check(bus_wire, 14'h0155);
        check(14'(range_exceed_flag), 14'h0000);
        @(negedge clock);
        #1;
        check(bus_wire, 14'h2aaa);
        check(14'(range_exceed_flag), 14'h0001);
        @(negedge clock);
        #1;
        check(bus_wire, 14'h0155);
        host_u.close_read();
        host_u.write_reg(SEL_RESULT, 14'h3fff);
        check(14'(gain_code), 14'h0007);
        $display("test latency finished");
        host_u.open_read(SEL_GAIN);
        for (int i = 0; i < 9; i++) begin
            host_u.write_reg(SEL_GAIN, (i < 8) ? 14'(7 - i) : 14'h0005);
        end
        check(14'(write_ready), 14'h0000);
        check(14'(gain_code), 14'h0007);
        host_u.close_read();
        repeat (15) @(negedge clock);
        check(14'(gain_code), 14'h0000);
        check(14'(write_ready), 14'h0001);
        $display("test write_buffer finished");
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire

// *** bench/arp_host_model.sv ***
// Host processor model on the parallel register port
`timescale 1ns/1ps
`default_nettype none
module arp_host_model
    import arp_pkg::*;
(
    input wire logic clock,
    input wire logic [DATA_W-1:0] data_bus,
    output logic cs_n,
    output logic oe_n,
    output logic wr_n,
    output logic register_select_high,
    output logic register_select_low,
    output logic [DATA_W-1:0] data_in
);
    initial begin
        cs_n = 1'b1;
        oe_n = 1'b1;
        wr_n = 1'b1;
        {register_select_high, register_select_low} = SEL_RESULT;
        data_in = 14'h0000;
    end
    task automatic write_reg(input logic [SEL_W-1:0] sel,
            input logic [DATA_W-1:0] d);
        @(negedge clock);
        {register_select_high, register_select_low} = sel;
        cs_n = 1'b0;
        data_in = (sel == SEL_CTRL) ? (d & 14'h3f80) : d;
        @(negedge clock);
        wr_n = 1'b0;
        repeat (3) @(negedge clock);
        wr_n = 1'b1;
        repeat (3) @(negedge clock);
        cs_n = 1'b1;
        // Released data lines must not look like the last word
        data_in = ~data_in;
        repeat (3) @(negedge clock);
    endtask
    task automatic open_read(input logic [SEL_W-1:0] sel);
        @(negedge clock);
        {register_select_high, register_select_low} = sel;
        oe_n = 1'b0;
    endtask
    task automatic close_read();
        @(negedge clock);
        oe_n = 1'b1;
    endtask
    task automatic read_reg(input logic [SEL_W-1:0] sel,
            output logic [DATA_W-1:0] d);
        open_read(sel);
        repeat (4) @(posedge clock);
        d = data_bus;
        close_read();
    endtask
endmodule
`default_nettype wire

// *** bench/arp_properties.sv ***
// Port checker for the converter register port
`timescale 1ns/1ps
`default_nettype none
module arp_checker
    import arp_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic oe_n,
    input wire logic register_select_high,
    input wire logic register_select_low,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic data_oe,
    input wire logic core_range_exceed,
    input wire logic range_exceed_flag,
    input wire logic [GAIN_W-1:0] gain_code,
    input wire logic power_down_bit,
    input wire logic external_reference,
    input wire logic [TEST_W-1:0] test_input_select,
    input wire logic test_mode_active
);
    logic [3:0] warm_reg;
    logic [3:0] warm_next;
    // Pipeline still holds reset zeros until the count is past 10
    always_comb begin
        warm_next = (warm_reg == 4'hf) ? warm_reg : warm_reg + 4'h1;
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            warm_reg <= 4'h0;
        end else begin
            warm_reg <= warm_next;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    sequence read_held(logic [SEL_W-1:0] sel);
        ({register_select_high, register_select_low} == sel && !oe_n) [*4];
    endsequence
    a_flag_latency: assert property (warm_reg > 4'ha |->
        range_exceed_flag == $past(core_range_exceed, 10))
        else $error("range flag latency wrong");
    a_reset_clear: assert property ($rose(arst_n) |-> gain_code == 3'h0
        && !power_down_bit && !external_reference && !data_oe
        && test_input_select == 3'h0) else $error("outputs not cleared");
    a_oe_drive: assert property ($fell(oe_n) |-> ##[1:3] data_oe)
        else $error("data lines not driven");
    a_oe_release: assert property ($rose(oe_n) |-> ##[1:3] !data_oe)
        else $error("data lines not released");
    a_idle_hiz: assert property (oe_n [*4] |-> !data_oe)
        else $error("data driven while disabled");
    a_test_mode: assert property ($stable(test_input_select) [*2] |->
        test_mode_active == (test_input_select[1:0] != 2'h0))
        else $error("test mode flag wrong");
    a_gain_read: assert property (read_held(SEL_GAIN) |-> data_oe
        && data_out == {11'h000, gain_code}) else $error("gain readback");
    a_trim_read: assert property (read_held(SEL_TRIM) |-> data_oe
        && data_out[13:8] == 6'h00) else $error("trim upper bits");
    a_ctrl_read: assert property (read_held(SEL_CTRL) |->
        data_out[13] == power_down_bit && data_out[12] == external_reference
        && data_out[10:8] == test_input_select && data_out[6:0] == 7'h00)
        else $error("control readback");
endmodule
bind arp_top arp_checker chk_u (.clock, .arst_n, .oe_n, .register_select_high,
    .register_select_low, .data_out, .data_oe, .core_range_exceed,
    .range_exceed_flag, .gain_code, .power_down_bit, .external_reference,
    .test_input_select, .test_mode_active);
`default_nettype wire

// *** design/arp_fifo.sv ***
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module arp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic arst_n,
    arp_stream_if.buffer chan
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] FULL_COUNT = (PTR_W + 1)'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
    logic [PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
    logic [PTR_W:0] count_reg, count_next;
    logic push;
    logic pop;

    function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
        bump = (p == LAST_PTR) ? '0 : p + 1'b1;
    endfunction

    assign chan.in_ready = (count_reg != FULL_COUNT);
    assign chan.out_valid = (count_reg != '0);
    assign chan.out_data = mem_reg[rd_ptr_reg];
    assign push = chan.in_valid && chan.in_ready;
    assign pop = chan.out_valid && chan.out_ready;

    always_comb begin
        mem_next = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        if (push) begin
            mem_next[wr_ptr_reg] = chan.in_data;
            wr_ptr_next = bump(wr_ptr_reg);
        end
        if (pop) begin
            rd_ptr_next = bump(rd_ptr_reg);
        end
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            mem_reg <= mem_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
    end
endmodule
`default_nettype wire

// *** design/arp_pkg.sv ***
// Shared constants for the converter host register port
package arp_pkg;

    // Data path widths
    localparam int DATA_W = 14;
    localparam int SEL_W = 2;
    localparam int GAIN_W = 3;
    localparam int TRIM_W = 8;
    localparam int TEST_W = 3;
    localparam int CTRL_W = 7;
    localparam int WR_W = SEL_W + DATA_W;
    localparam int SYNC_W = 3 + SEL_W + DATA_W;
    localparam int FIFO_DEPTH = 8;

    // Register select codes
    localparam logic [SEL_W-1:0] SEL_RESULT = 2'h0;
    localparam logic [SEL_W-1:0] SEL_GAIN = 2'h1;
    localparam logic [SEL_W-1:0] SEL_TRIM = 2'h2;
    localparam logic [SEL_W-1:0] SEL_CTRL = 2'h3;

    // Field positions in the 14-bit data word
    localparam int GAIN_LSB = 0;
    localparam int TRIM_LSB = 0;
    localparam int CTRL_LSB = 7;
    localparam int POWER_DOWN_POS = 13;
    localparam int EXT_REF_POS = 12;
    localparam int CODE_STYLE_POS = 11;
    localparam int TEST_SEL_LSB = 8;
    localparam int TRIM_BYPASS_POS = 7;

    // Reset values
    localparam logic [GAIN_W-1:0] GAIN_RESET = 3'h0;
    localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h00;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
    localparam logic [DATA_W-1:0] DATA_RESET = 14'h0000;

    // Output coding
    localparam logic [DATA_W-1:0] CODE_MAX = 14'h3fff;
    localparam logic [DATA_W-1:0] CODE_MIN = 14'h0000;
    localparam logic [DATA_W-1:0] TWOS_FLIP = 14'h2000;

    // Test input codes that leave the normal input connected
    localparam logic [TEST_W-1:0] TEST_NORMAL_A = 3'h0;
    localparam logic [TEST_W-1:0] TEST_NORMAL_B = 3'h4;

    // Latency of 9.5 clock cycles, held as half cycles
    localparam int LATENCY_HALF_CYCLES = 19;
    localparam int PIPE_STAGES = (LATENCY_HALF_CYCLES + 1) / 2;

endpackage

// *** design/arp_stream_if.sv ***
// Valid/ready channel between the port logic and its write buffer
`timescale 1ns/1ps
`default_nettype none
interface arp_stream_if #(parameter int WIDTH = 16);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;

    modport buffer (
        input in_valid,
        input in_data,
        input out_ready,
        output in_ready,
        output out_valid,
        output out_data
    );

    modport user (
        output in_valid,
        output in_data,
        output out_ready,
        input in_ready,
        input out_valid,
        input out_data
    );
endinterface
`default_nettype wire

// *** design/arp_top.sv ***
// Host register port and output coding of a 14-bit pipelined converter
`timescale 1ns/1ps
`default_nettype none
module arp_top
    import arp_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic oe_n,
    input wire logic wr_n,
    input wire logic register_select_high,
    input wire logic register_select_low,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic [DATA_W-1:0] core_sample_code,
    input wire logic core_range_exceed,
    output logic range_exceed_flag,
    output logic [GAIN_W-1:0] gain_code,
    output logic power_down_bit,
    output logic external_reference,
    output logic [TEST_W-1:0] test_input_select,
    output logic test_mode_active,
    output logic write_ready
);

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Signed trim added to a binary code, clamped to the code range
    function automatic logic [DATA_W-1:0] apply_trim(
        input logic [DATA_W-1:0] code,
        input logic [TRIM_W-1:0] trim
    );
        logic signed [DATA_W+1:0] sum;
        sum = $signed({2'b00, code}) + $signed(trim);
        if (sum < 0) begin
            apply_trim = CODE_MIN;
        end else if (sum > $signed({2'b00, CODE_MAX})) begin
            apply_trim = CODE_MAX;
        end else begin
            apply_trim = sum[DATA_W-1:0];
        end
    endfunction

    // Straight binary passes through; twos complement flips the MSB
    function automatic logic [DATA_W-1:0] apply_style(
        input logic [DATA_W-1:0] code,
        input logic twos
    );
        apply_style = twos ? (code ^ TWOS_FLIP) : code;
    endfunction

    // True for the two test codes that keep the normal input
    function automatic logic is_normal_input(input logic [TEST_W-1:0] sel);
        is_normal_input = (sel == TEST_NORMAL_A) || (sel == TEST_NORMAL_B);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [SYNC_W-1:0] pin_s1_reg, pin_s1_next;
    logic [SYNC_W-1:0] pin_s2_reg, pin_s2_next;
    logic wr_prev_reg, wr_prev_next;
    logic cs_n_s;
    logic oe_n_s;
    logic wr_n_s;
    logic [SEL_W-1:0] sel_s;
    logic [DATA_W-1:0] data_s;

    always_comb begin
        pin_s1_next = {cs_n, oe_n, wr_n, register_select_high,
                       register_select_low, data_in};
        pin_s2_next = pin_s1_reg;
        wr_prev_next = wr_n_s;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_reg <= '1;
            pin_s2_reg <= '1;
            wr_prev_reg <= 1'b1;
        end else begin
            pin_s1_reg <= pin_s1_next;
            pin_s2_reg <= pin_s2_next;
            wr_prev_reg <= wr_prev_next;
        end
    end

    assign cs_n_s = pin_s2_reg[SYNC_W-1];
    assign oe_n_s = pin_s2_reg[SYNC_W-2];
    assign wr_n_s = pin_s2_reg[SYNC_W-3];
    assign sel_s = pin_s2_reg[DATA_W +: SEL_W];
    assign data_s = pin_s2_reg[DATA_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Write capture into the write buffer

    arp_stream_if #(.WIDTH(WR_W)) wr_chan ();

    arp_fifo #(
        .WIDTH(WR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .clock(clock),
        .arst_n(arst_n),
        .chan(wr_chan)
    );

    logic wr_rise;
    logic write_ready_reg, write_ready_next;

    // Rising strobe edge while chip select is low
    assign wr_rise = wr_n_s && !wr_prev_reg && !cs_n_s;
    assign wr_chan.in_valid = wr_rise;
    assign wr_chan.in_data = {sel_s, data_s};
    // Writes drain only while no read is open, so read-back stays steady
    assign wr_chan.out_ready = oe_n_s;

    always_comb begin
        write_ready_next = wr_chan.in_ready;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            write_ready_reg <= 1'b0;
        end else begin
            write_ready_reg <= write_ready_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    logic [GAIN_W-1:0] gain_reg, gain_next;
    logic [TRIM_W-1:0] trim_reg, trim_next;
    logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
    logic [SEL_W-1:0] apply_sel;
    logic [DATA_W-1:0] apply_data;
    logic [DATA_W-1:0] ctrl_word;

    assign apply_sel = wr_chan.out_data[DATA_W +: SEL_W];
    assign apply_data = wr_chan.out_data[DATA_W-1:0];

    always_comb begin
        gain_next = gain_reg;
        trim_next = trim_reg;
        ctrl_next = ctrl_reg;
        if (wr_chan.out_valid && wr_chan.out_ready) begin
            case (apply_sel)
                SEL_GAIN: begin
                    gain_next = apply_data[GAIN_LSB +: GAIN_W];
                end
                SEL_TRIM: begin
                    trim_next = apply_data[TRIM_LSB +: TRIM_W];
                end
                SEL_CTRL: begin
                    // Spare bits are expected zero and are not stored
                    ctrl_next = apply_data[CTRL_LSB +: CTRL_W];
                end
                default: begin
                    // Result register is read-only
                    gain_next = gain_reg;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            gain_reg <= GAIN_RESET;
            trim_reg <= TRIM_RESET;
            ctrl_reg <= CTRL_RESET;
        end else begin
            gain_reg <= gain_next;
            trim_reg <= trim_next;
            ctrl_reg <= ctrl_next;
        end
    end

    assign ctrl_word = {ctrl_reg, {CTRL_LSB{1'b0}}};

    ////////////////////////////////////////////////////////////////////////
    // Conversion pipeline, sample taken at edge zero

    logic [DATA_W:0] pipe_reg [PIPE_STAGES];
    logic [DATA_W:0] pipe_next [PIPE_STAGES];
    logic [DATA_W-1:0] tail_code;
    logic tail_over;
    logic [DATA_W-1:0] trimmed_code;
    logic [DATA_W-1:0] coded_result;

    always_comb begin
        pipe_next[0] = {core_range_exceed, core_sample_code};
        for (int i = 1; i < PIPE_STAGES; i++) begin
            pipe_next[i] = pipe_reg[i-1];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < PIPE_STAGES; i++) begin
                pipe_reg[i] <= '0;
            end
        end else begin
            pipe_reg <= pipe_next;
        end
    end

    assign tail_over = pipe_reg[PIPE_STAGES-1][DATA_W];
    assign tail_code = pipe_reg[PIPE_STAGES-1][DATA_W-1:0];

    // Core code is straight binary; trim then coding style
    always_comb begin
        if (ctrl_word[TRIM_BYPASS_POS]) begin
            trimmed_code = tail_code;
        end else begin
            trimmed_code = apply_trim(tail_code, trim_reg);
        end
        coded_result = apply_style(trimmed_code, ctrl_word[CODE_STYLE_POS]);
    end

    ////////////////////////////////////////////////////////////////////////
    // Output stage, on the falling edge for the extra half cycle

    logic [DATA_W-1:0] data_out_reg, data_out_next;
    logic data_oe_reg, data_oe_next;
    logic over_reg, over_next;

    always_comb begin
        data_oe_next = !oe_n_s;
        over_next = tail_over;
        case (sel_s)
            SEL_RESULT: begin
                data_out_next = coded_result;
            end
            SEL_GAIN: begin
                data_out_next = DATA_W'(gain_reg);
            end
            SEL_TRIM: begin
                data_out_next = DATA_W'(trim_reg);
            end
            SEL_CTRL: begin
                data_out_next = ctrl_word;
            end
            default: begin
                data_out_next = DATA_RESET;
            end
        endcase
    end

    always_ff @(negedge clock or negedge arst_n) begin
        if (!arst_n) begin
            data_out_reg <= DATA_RESET;
            data_oe_reg <= 1'b0;
            over_reg <= 1'b0;
        end else begin
            data_out_reg <= data_out_next;
            data_oe_reg <= data_oe_next;
            over_reg <= over_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Analog core controls

    logic test_active_reg, test_active_next;

    always_comb begin
        test_active_next =
            !is_normal_input(ctrl_word[TEST_SEL_LSB +: TEST_W]);
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            test_active_reg <= 1'b0;
        end else begin
            test_active_reg <= test_active_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port drive

    assign data_out = data_out_reg;
    assign data_oe = data_oe_reg;
    assign range_exceed_flag = over_reg;
    assign gain_code = gain_reg;
    assign power_down_bit = ctrl_reg[POWER_DOWN_POS-CTRL_LSB];
    assign external_reference = ctrl_reg[EXT_REF_POS-CTRL_LSB];
    assign test_input_select = ctrl_reg[TEST_SEL_LSB-CTRL_LSB +: TEST_W];
    assign test_mode_active = test_active_reg;
    assign write_ready = write_ready_reg;

endmodule
`default_nettype wire
